// >>> verilog/mpp_ports.sv
// Purpose: pin logic of ports A, B, C and the two strobe pins
// Assumes: pins are asynchronous, mode strap is stable around reset release
// Notes: in expanded mode every access runs a multiplexed bus cycle
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/100ps

module mpp_ports import mpp_pkg::*; #(
	parameter int unsigned ADDR_CYC_P = ADDR_CYC,
	parameter int unsigned DATA_CYC_P = DATA_CYC,
	parameter int unsigned STB_CYC_P = STB_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	output logic [7:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [0:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic mode_expanded_i,
	input wire logic [7:0] timer_pin_i,
	output logic [7:0] timer_pin_o,
	output logic [7:0] timer_pin_oe_n_o,
	input wire logic [4:0] compare_level_i,
	output logic [3:0] capture_level_o,
	output logic pulse_accum_o,
	output logic [7:0] high_address_pins_o,
	input wire logic [7:0] muxed_addr_data_pins_i,
	output logic [7:0] muxed_addr_data_pins_o,
	output logic [7:0] muxed_addr_data_pins_oe_n_o,
	input wire logic strobe_a_pin_i,
	output logic strobe_a_pin_o,
	output logic strobe_a_pin_oe_n_o,
	output logic strobe_b_pin_o,
	output logic strobe_b_pin_oe_n_o,
	output logic e_clk_o
);

	if (DATA_CYC_P < 3 || DATA_CYC_P > 255 || ADDR_CYC_P < 1 || ADDR_CYC_P > 255) begin : g_chk_phase
		$error("bus phase lengths must be 1..255, data phase at least 3");
	end
	if (STB_CYC_P < 1 || STB_CYC_P > 255) begin : g_chk_stb
		$error("strobe pulse length must be 1..255");
	end

	logic [7:0] pa_s1_r, pa_s2_r, pc_s1_r, pc_s2_r;
	logic sa_s1_r, sa_s2_r, sa_prev_r, md_s1_r, md_s2_r;
	logic exp_r, mode_seen_r;
	logic [7:0] tpd_r, pac_r, pio_r, pcd_r, pcdir_r, opd_r, sli_r, own_r, fcs_r;
	logic flag_r, hs_rdy_r;
	logic [7:0] stb_cnt_r;
	mpp_bus_st_t st_r;
	logic [7:0] cnt_r;
	logic [15:0] adr_r;
	logic [7:0] wdat_r;
	logic we_r, int_r, rw_r, rw_hz_r, ack_r;
	logic [7:0] rd_r, int_rd;
	logic [7:0] pa_o_r, pa_oe_n_r, pa_drv_nxt, pa_oen_nxt, pa_read;
	logic [7:0] pc_o_nxt, pc_oen_nxt;
	logic req, in_win, is_int, wr_fire, rd_fire, edge_act, start, data_end;
	logic [3:0] off;

	assign req = wb_cyc_i & wb_stb_i;
	assign off = wb_adr_i[3:0];
	assign in_win = (wb_adr_i[15:REG_WIN_LSB] == REG_BASE[15:REG_WIN_LSB]);
	assign is_int = in_win & ~(exp_r & (off == OFF_OUTPUT_PORT_DATA));
	assign wb_ack_o = exp_r ? (st_r == ST_ACK) : ack_r;
	assign wr_fire = req & wb_we_i & wb_sel_i[0] & wb_ack_o & is_int;
	assign rd_fire = req & ~wb_we_i & wb_ack_o & is_int;
	assign start = exp_r & req & (st_r == ST_IDLE);
	assign data_end = (st_r == ST_DATA) & (cnt_r == 8'h00);

	// two-flop synchronisers; first stage read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_s1_r <= BYTE_ZERO;
			pa_s2_r <= BYTE_ZERO;
			pc_s1_r <= BYTE_ZERO;
			pc_s2_r <= BYTE_ZERO;
			sa_s1_r <= 1'b0;
			sa_s2_r <= 1'b0;
			sa_prev_r <= 1'b0;
		end else begin
			pa_s1_r <= timer_pin_i;
			pa_s2_r <= pa_s1_r;
			pc_s1_r <= muxed_addr_data_pins_i;
			pc_s2_r <= pc_s1_r;
			sa_s1_r <= strobe_a_pin_i;
			sa_s2_r <= sa_s1_r;
			sa_prev_r <= sa_s2_r;
		end
	end

	// strap flops run through reset, so the level is settled when it is caught
	always_ff @(posedge clk_i) begin
		md_s1_r <= mode_expanded_i;
		md_s2_r <= md_s1_r;
	end
	// strap caught once after release; mode cannot change while running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exp_r <= 1'b0;
			mode_seen_r <= 1'b0;
		end else if (!mode_seen_r) begin
			exp_r <= md_s2_r;
			mode_seen_r <= 1'b1;
		end
	end

	// register file
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tpd_r <= BYTE_ZERO;
			pac_r <= PAC_RST;
			pio_r <= PIO_RST;
			pcd_r <= BYTE_ZERO;
			pcdir_r <= BYTE_ZERO;
			opd_r <= BYTE_ZERO;
			own_r <= BYTE_ZERO;
			fcs_r <= BYTE_ZERO;
		end else if (wr_fire) begin
			case (off)
				OFF_TIMER_PORT_DATA: tpd_r <= wb_dat_i;
				OFF_PULSE_ACCUM_CONTROL: pac_r <= wb_dat_i;
				OFF_PARALLEL_IO_CONTROL: pio_r <= wb_dat_i;
				OFF_PORTC_DATA: pcd_r <= wb_dat_i;
				OFF_OUTPUT_PORT_DATA: opd_r <= wb_dat_i;
				OFF_TIMER_OWN: own_r <= wb_dat_i;
				OFF_PORTC_DIR: pcdir_r <= wb_dat_i;
				OFF_FIRST_COMPARE_SEL: fcs_r <= wb_dat_i;
				default: ;
			endcase
		end
	end

	// input strobe edge latches port C; flag set beats a clear
	assign edge_act = ~exp_r & (pio_r[PIO_RISING_EDGE] ? (sa_s2_r & ~sa_prev_r) : (~sa_s2_r & sa_prev_r));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sli_r <= BYTE_ZERO;
			flag_r <= 1'b0;
		end else begin
			if (edge_act) begin
				sli_r <= pc_s2_r;
			end
			if (edge_act) begin
				flag_r <= 1'b1;
			end else if (wr_fire && off == OFF_PARALLEL_IO_CONTROL && wb_dat_i[PIO_STROBE_FLAG]) begin
				flag_r <= 1'b0;
			end
		end
	end

	// full handshake: ready drops on strobe edge, returns when latch is read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_rdy_r <= 1'b1;
		end else if (edge_act) begin
			hs_rdy_r <= 1'b0;
		end else if (rd_fire && off == OFF_STROBE_LATCHED_INPUT) begin
			hs_rdy_r <= 1'b1;
		end
	end

	// simple strobed output pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stb_cnt_r <= BYTE_ZERO;
		end else if (wr_fire && off == OFF_OUTPUT_PORT_DATA && !pio_r[PIO_FULL_HANDSHAKE]) begin
			stb_cnt_r <= 8'(STB_CYC_P);
		end else if (stb_cnt_r != BYTE_ZERO) begin
			stb_cnt_r <= stb_cnt_r - 8'h01;
		end
	end

	// register read mux
	always_comb begin
		int_rd = BYTE_ZERO;
		case (off)
			OFF_TIMER_PORT_DATA: int_rd = pa_read;
			OFF_PULSE_ACCUM_CONTROL: int_rd = pac_r;
			OFF_PARALLEL_IO_CONTROL: begin
				int_rd = pio_r;
				int_rd[PIO_STROBE_FLAG] = flag_r;
				int_rd[PIO_MODE_EXPANDED] = exp_r;
			end
			OFF_PORTC_DATA: int_rd = (pcdir_r & pcd_r) | (~pcdir_r & pc_s2_r);
			OFF_OUTPUT_PORT_DATA: int_rd = opd_r;
			OFF_STROBE_LATCHED_INPUT: int_rd = sli_r;
			OFF_TIMER_OWN: int_rd = own_r;
			OFF_PORTC_DIR: int_rd = pcdir_r;
			OFF_FIRST_COMPARE_SEL: int_rd = fcs_r;
			default: int_rd = BYTE_ZERO;
		endcase
	end

	// single-chip answer: one wait cycle, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rd_r <= BYTE_ZERO;
		end else if (!exp_r) begin
			ack_r <= req & ~ack_r;
			if (req && !ack_r) begin
				rd_r <= in_win ? int_rd : BYTE_ZERO;
			end
		end else begin
			ack_r <= 1'b0;
			if (data_end) begin
				rd_r <= int_r ? int_rd : pc_s2_r;
			end
		end
	end
	assign wb_dat_o = rd_r;

	// expanded bus cycle sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			cnt_r <= BYTE_ZERO;
			adr_r <= 16'h0000;
			wdat_r <= BYTE_ZERO;
			we_r <= 1'b0;
			int_r <= 1'b0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (start) begin
						st_r <= ST_ADDR;
						cnt_r <= 8'(ADDR_CYC_P - 1);
						adr_r <= wb_adr_i;
						wdat_r <= wb_dat_i;
						we_r <= wb_we_i & wb_sel_i[0];
						int_r <= is_int;
					end
				end
				ST_ADDR: begin
					if (cnt_r == 8'h00) begin
						st_r <= ST_DATA;
						cnt_r <= 8'(DATA_CYC_P - 1);
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				ST_DATA: begin
					if (cnt_r == 8'h00) begin
						st_r <= ST_ACK;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				ST_ACK: st_r <= ST_IDLE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// direction only moves when an external cycle starts, so write runs keep it low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rw_r <= 1'b1;
			rw_hz_r <= 1'b0;
		end else if (start) begin
			rw_hz_r <= is_int;
			if (!is_int) begin
				rw_r <= ~(wb_we_i & wb_sel_i[0]);
			end
		end else if (st_r == ST_ACK) begin
			rw_hz_r <= 1'b0;
		end
	end

	// port A drive selection; timer-owned pins ignore the latch
	always_comb begin
		pa_drv_nxt = tpd_r;
		pa_oen_nxt = BYTE_ONES;
		pa_drv_nxt[PA_PIN_SEVEN] = own_r[PA_PIN_SEVEN] ? compare_level_i[CMP_FIRST] : tpd_r[PA_PIN_SEVEN];
		pa_oen_nxt[PA_PIN_SEVEN] = ~(own_r[PA_PIN_SEVEN] | pac_r[PAC_DIR_BIT_SEVEN]);
		for (int i = PA_MID_LO; i <= PA_MID_HI; i++) begin
			if (own_r[i]) begin
				pa_drv_nxt[i] = fcs_r[i] ? compare_level_i[CMP_FIRST] : compare_level_i[CMP_MID_BASE - i];
			end
			pa_oen_nxt[i] = 1'b0;
		end
		if (own_r[PA_PIN_THREE] && pac_r[PAC_SHARED_IS_CAPTURE]) begin
			pa_oen_nxt[PA_PIN_THREE] = 1'b1;
		end else if (own_r[PA_PIN_THREE]) begin
			pa_drv_nxt[PA_PIN_THREE] = fcs_r[PA_PIN_THREE] ? compare_level_i[CMP_FIRST] : compare_level_i[CMP_FIFTH];
			pa_oen_nxt[PA_PIN_THREE] = 1'b0;
		end else begin
			pa_oen_nxt[PA_PIN_THREE] = ~pac_r[PAC_DIR_BIT_THREE];
		end
	end
	assign pa_read = (pa_oe_n_r & pa_s2_r) | (~pa_oe_n_r & pa_o_r);
	assign timer_pin_o = pa_o_r;
	assign timer_pin_oe_n_o = pa_oe_n_r;

	// port C drive selection
	always_comb begin
		pc_o_nxt = pcd_r;
		pc_oen_nxt = ~pcdir_r;
		if (exp_r) begin
			pc_o_nxt = adr_r[7:0];
			pc_oen_nxt = BYTE_ONES;
			if (st_r == ST_ADDR) begin
				pc_oen_nxt = BYTE_ZERO;
			end else if (st_r == ST_DATA && we_r) begin
				pc_o_nxt = wdat_r;
				pc_oen_nxt = BYTE_ZERO;
			end else if (st_r == ST_DATA && int_r && pio_r[PIO_INTERNAL_READ_VISIBILITY]) begin
				pc_o_nxt = int_rd;
				pc_oen_nxt = BYTE_ZERO;
			end
		end else if (pio_r[PIO_OPEN_DRAIN_SELECT]) begin
			pc_o_nxt = BYTE_ZERO;
			pc_oen_nxt = ~(pcdir_r & ~pcd_r);
		end
	end

	// registered pins; port A ignores the mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_o_r <= BYTE_ZERO;
			pa_oe_n_r <= BYTE_ONES;
			muxed_addr_data_pins_o <= BYTE_ZERO;
			muxed_addr_data_pins_oe_n_o <= BYTE_ONES;
			high_address_pins_o <= BYTE_ZERO;
			strobe_a_pin_o <= 1'b0;
			strobe_a_pin_oe_n_o <= 1'b1;
			strobe_b_pin_o <= 1'b0;
			strobe_b_pin_oe_n_o <= 1'b1;
			e_clk_o <= 1'b0;
			capture_level_o <= 4'h0;
			pulse_accum_o <= 1'b0;
		end else begin
			pa_o_r <= pa_drv_nxt;
			pa_oe_n_r <= pa_oen_nxt;
			muxed_addr_data_pins_o <= pc_o_nxt;
			muxed_addr_data_pins_oe_n_o <= pc_oen_nxt;
			high_address_pins_o <= exp_r ? adr_r[15:8] : opd_r;
			strobe_a_pin_o <= exp_r & (st_r == ST_ADDR);
			strobe_a_pin_oe_n_o <= ~exp_r;
			if (exp_r) begin
				strobe_b_pin_o <= rw_r;
				strobe_b_pin_oe_n_o <= rw_hz_r;
			end else begin
				strobe_b_pin_o <= pio_r[PIO_STROBE_ACTIVE_HIGH] ~^
					(pio_r[PIO_FULL_HANDSHAKE] ? hs_rdy_r : (stb_cnt_r != BYTE_ZERO));
				strobe_b_pin_oe_n_o <= 1'b0;
			end
			e_clk_o <= exp_r & (st_r == ST_DATA);
			capture_level_o[2:0] <= {pa_s2_r[0], pa_s2_r[1], pa_s2_r[2]};
			capture_level_o[3] <= fcs_r[FCS_TRIGGER_CAPTURE] ? compare_level_i[CMP_FIRST] : pa_s2_r[PA_PIN_THREE];
			pulse_accum_o <= pa_read[PA_PIN_SEVEN];
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_AS_PULSE: assert property (exp_r && st_r == ST_ADDR |=> strobe_a_pin_o && !strobe_a_pin_oe_n_o)
		else $error("address strobe missing in address phase");
	AST_RW_DIR: assert property (st_r == ST_DATA && !int_r |-> rw_r == !we_r)
		else $error("direction pin disagrees with cycle direction");
	AST_RW_HOLD: assert property (exp_r && !rw_r && !(start && !wb_we_i) |=> !rw_r)
		else $error("direction pin rose between writes");
	AST_PB_ADDR: assert property (exp_r && st_r == ST_DATA |=> high_address_pins_o == adr_r[15:8])
		else $error("port B lost high address");
	AST_STB_PULSE: assert property (!exp_r && wr_fire && off == OFF_OUTPUT_PORT_DATA &&
		!pio_r[PIO_FULL_HANDSHAKE] |=> ##1 (strobe_b_pin_o == pio_r[PIO_STROBE_ACTIVE_HIGH])[*2])
		else $error("output strobe pulse missing");
	AST_PB_EXT: assert property (exp_r && req && st_r == ST_IDLE && in_win &&
		off == OFF_OUTPUT_PORT_DATA |=> st_r == ST_ADDR && !int_r)
		else $error("port B access not external");
	AST_LATCH: assert property (edge_act |=> sli_r == $past(pc_s2_r) && flag_r)
		else $error("strobe edge did not latch port C");
	AST_OPEN_DRAIN: assert property ($past(!exp_r && pio_r[PIO_OPEN_DRAIN_SELECT]) |->
		(muxed_addr_data_pins_o & ~muxed_addr_data_pins_oe_n_o) == BYTE_ZERO)
		else $error("open-drain pin driven high");
	AST_PA_READ: assert property (!own_r[PA_PIN_THREE] && pac_r[PAC_DIR_BIT_THREE] |=>
		pa_read[PA_PIN_THREE] == $past(tpd_r[PA_PIN_THREE]))
		else $error("port A output read wrong level");

endmodule : mpp_ports

// >>> verilog/mpp_pkg.sv
// Purpose: shared constants and types of the mode-muxed parallel ports
// Assumes: 125 MHz system clock, 8-bit classic Wishbone register access
// Notes: phase times are in ns; cycle counts derive from them
package mpp_pkg;

	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned ADDR_PHASE_NS = 16;
	localparam int unsigned DATA_PHASE_NS = 32;
	localparam int unsigned STROBE_PULSE_NS = 16;
	// least times round up to whole cycles
	localparam int unsigned ADDR_CYC = (ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DATA_CYC = (DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STB_CYC = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register window
	localparam logic [15:0] REG_BASE = 16'h1000;
	localparam int unsigned REG_WIN_LSB = 4;
	localparam logic [3:0] OFF_TIMER_PORT_DATA = 4'h0;
	localparam logic [3:0] OFF_PULSE_ACCUM_CONTROL = 4'h1;
	localparam logic [3:0] OFF_PARALLEL_IO_CONTROL = 4'h2;
	localparam logic [3:0] OFF_PORTC_DATA = 4'h3;
	localparam logic [3:0] OFF_OUTPUT_PORT_DATA = 4'h4;
	localparam logic [3:0] OFF_STROBE_LATCHED_INPUT = 4'h5;
	localparam logic [3:0] OFF_TIMER_OWN = 4'h6;
	localparam logic [3:0] OFF_PORTC_DIR = 4'h7;
	localparam logic [3:0] OFF_FIRST_COMPARE_SEL = 4'h8;

	// pulse_accum_control fields
	localparam int unsigned PAC_DIR_BIT_SEVEN = 7;
	localparam int unsigned PAC_DIR_BIT_THREE = 3;
	localparam int unsigned PAC_SHARED_IS_CAPTURE = 2;
	// parallel_io_control fields
	localparam int unsigned PIO_STROBE_FLAG = 7;
	localparam int unsigned PIO_MODE_EXPANDED = 6;
	localparam int unsigned PIO_OPEN_DRAIN_SELECT = 5;
	localparam int unsigned PIO_FULL_HANDSHAKE = 4;
	localparam int unsigned PIO_RISING_EDGE = 3;
	localparam int unsigned PIO_STROBE_ACTIVE_HIGH = 2;
	localparam int unsigned PIO_INTERNAL_READ_VISIBILITY = 1;
	// first compare select: bit 0 lets first compare edges trigger the fourth capture
	localparam int unsigned FCS_TRIGGER_CAPTURE = 0;

	// port A pin roles
	localparam int unsigned PA_PIN_SEVEN = 7;
	localparam int unsigned PA_PIN_THREE = 3;
	localparam int unsigned PA_MID_LO = 4;
	localparam int unsigned PA_MID_HI = 6;
	localparam int unsigned CMP_FIRST = 0;
	localparam int unsigned CMP_FIFTH = 4;
	localparam int unsigned CMP_MID_BASE = 7;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] PIO_RST = 8'h00;
	localparam logic [7:0] PAC_RST = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_ACK = 2'b11
	} mpp_bus_st_t;

endpackage : mpp_pkg

// >>> verification/mpp_ext_model.sv
// Purpose: far side of ports B and C: external memory on the muxed bus
// Assumes: pull-ups on every port C line; address latched on the address strobe
// Notes: read data is a fixed function of the latched address, no wait states
`timescale 1ns/100ps
module mpp_ext_model (
	input wire logic clk_i,
	input wire logic [7:0] high_address_pins_i,
	input wire logic [7:0] pc_o_i,
	input wire logic [7:0] pc_oe_n_i,
	input wire logic as_i,
	input wire logic rw_i,
	input wire logic e_clk_i,
	input wire logic sc_drive_i,
	input wire logic [7:0] sc_val_i,
	output logic [7:0] pc_wire_o,
	output logic [15:0] last_adr_o,
	output logic [7:0] last_wdat_o
);
	logic [15:0] lat_r = 16'h0000;
	logic cyc_r = 1'b0;
	logic e_q = 1'b0;
	logic en;
	logic [7:0] drv;
	// data is ready the moment the device releases the lines
	assign en = sc_drive_i | (cyc_r & rw_i);
	assign drv = sc_drive_i ? sc_val_i : (lat_r[7:0] ^ lat_r[15:8] ^ 8'h3c);
	// released lines float up through the pull-ups
	assign pc_wire_o = (~pc_oe_n_i & pc_o_i) | (pc_oe_n_i & (en ? drv : 8'hff));
	always_ff @(posedge clk_i) begin
		e_q <= e_clk_i;
		if (as_i) begin
			lat_r <= {high_address_pins_i, pc_wire_o};
			cyc_r <= 1'b1;
		end else if (e_q && !e_clk_i) begin
			cyc_r <= 1'b0;
		end
		if (cyc_r && e_clk_i && !rw_i) begin
			last_adr_o <= lat_r;
			last_wdat_o <= pc_wire_o;
		end
	end
endmodule : mpp_ext_model

// >>> verification/mpp_ports_bench.sv
// Purpose: self-checking bench of the parallel port pin logic
// Assumes: default phase lengths, mode strap changed only across a reset
// Notes: reads are scored from a queue by a separate monitor
`timescale 1ns/100ps
module mpp_ports_bench import mpp_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] adr = 16'h0000;
	logic [7:0] dat_w = 8'h00;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic mode = 1'b0;
	logic [7:0] timer_in = 8'h00;
	logic sa_in = 1'b0;
	logic sc_drive = 1'b0;
	logic [7:0] sc_val = 8'h00;
	logic [7:0] wb_dat_o, timer_pin_o, timer_pin_oe_n_o, hi_o, pc_o, pc_oe_n, pc_wire, last_wdat, v, r;
	logic [3:0] capture_level_o;
	logic [15:0] last_adr, a;
	logic wb_ack_o, pulse_accum_o, sa_o, sa_oe_n, sb_o, sb_oe_n, e_clk_o, sb_q;
	logic [7:0] rd_q[$];
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int sb_changes = 0;
	int n0;
	integer seed = 70503;

	mpp_ports i_mpp_ports (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
		.wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wb_ack_o),
		.mode_expanded_i(mode), .timer_pin_i(timer_in), .timer_pin_o(timer_pin_o),
		.timer_pin_oe_n_o(timer_pin_oe_n_o), .compare_level_i(5'h1f), .capture_level_o(capture_level_o),
		.pulse_accum_o(pulse_accum_o), .high_address_pins_o(hi_o), .muxed_addr_data_pins_i(pc_wire),
		.muxed_addr_data_pins_o(pc_o), .muxed_addr_data_pins_oe_n_o(pc_oe_n), .strobe_a_pin_i(sa_in),
		.strobe_a_pin_o(sa_o), .strobe_a_pin_oe_n_o(sa_oe_n), .strobe_b_pin_o(sb_o),
		.strobe_b_pin_oe_n_o(sb_oe_n), .e_clk_o(e_clk_o));
	mpp_ext_model i_mpp_ext_model (.clk_i(clk_i), .high_address_pins_i(hi_o), .pc_o_i(pc_o),
		.pc_oe_n_i(pc_oe_n), .as_i(sa_o & ~sa_oe_n), .rw_i(sb_o), .e_clk_i(e_clk_o), .sc_drive_i(sc_drive),
		.sc_val_i(sc_val), .pc_wire_o(pc_wire), .last_adr_o(last_adr), .last_wdat_o(last_wdat));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test

	// one classic cycle; read expectations go to the queue first
	task automatic wb(input logic [15:0] ad, input logic w, input logic [7:0] d, input logic [7:0] exp);
		if (!w) rd_q.push_back(exp);
		@(posedge clk_i);
		adr <= ad;
		we <= w;
		dat_w <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge clk_i iff wb_ack_o === 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// strap is only taken after a reset, so a mode change needs one
	task automatic do_reset(input logic m);
		@(posedge clk_i);
		mode <= m;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : do_reset

	function automatic logic [7:0] ext_rd(input logic [15:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h3c;
	endfunction : ext_rd

	always @(posedge clk_i) begin
		sb_q <= sb_o;
		if (sb_q !== sb_o) sb_changes++;
		if (wb_ack_o === 1'b1 && we === 1'b0 && rd_q.size() > 0) check(wb_dat_o, rd_q.pop_front());
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	initial begin
		do_reset(1'b0);
		check(sa_oe_n, 1'b1);
		for (int k = 0; k < 2; k++) begin
			v = 8'($random(seed));
			n0 = sb_changes;
			wb(16'h1004, 1'b1, v, 8'h00);
			repeat (6) @(posedge clk_i);
			check(hi_o, v);
			check(16'(sb_changes - n0), 16'h0002);
			wb(16'h1004, 1'b0, 8'h00, v);
		end
		// port C inputs latched on a rising input strobe
		wb(16'h1002, 1'b1, 8'h08, 8'h00);
		v = 8'($random(seed));
		sc_val <= v;
		sc_drive <= 1'b1;
		repeat (3) @(posedge clk_i);
		sa_in <= 1'b1;
		repeat (6) @(posedge clk_i);
		wb(16'h1005, 1'b0, 8'h00, v);
		// full handshake, falling input strobe, active-high ready
		wb(16'h1002, 1'b1, 8'h14, 8'h00);
		sa_in <= 1'b0;
		repeat (6) @(posedge clk_i);
		check(sb_o, 1'b0);
		wb(16'h1005, 1'b0, 8'h00, v);
		repeat (2) @(posedge clk_i);
		check(sb_o, 1'b1);
		sc_drive <= 1'b0;
		wb(16'h1002, 1'b1, 8'h20, 8'h00);
		wb(16'h1007, 1'b1, 8'hff, 8'h00);
		wb(16'h1003, 1'b1, 8'h5a, 8'h00);
		repeat (2) @(posedge clk_i);
		check(pc_oe_n, 8'h5a);
		check(pc_wire, 8'h5a);
		// port A: only bits 7 and 3 take a direction
		r = 8'($random(seed));
		timer_in <= r;
		wb(16'h1001, 1'b1, 8'h88, 8'h00);
		wb(16'h1000, 1'b1, 8'hff, 8'h00);
		repeat (4) @(posedge clk_i);
		check({timer_pin_oe_n_o[7], timer_pin_oe_n_o[3], timer_pin_oe_n_o[2:0]}, 5'b00111);
		check({timer_pin_o[7], timer_pin_o[3], pulse_accum_o}, 3'b111);
		check(capture_level_o, {r[3], r[0], r[1], r[2]});
		wb(16'h1000, 1'b0, 8'h00, 8'hf8 | {5'h00, r[2:0]});
		wb(16'h1006, 1'b1, 8'h80, 8'h00);
		wb(16'h1000, 1'b1, 8'h00, 8'h00);
		repeat (3) @(posedge clk_i);
		check(timer_pin_o[7], 1'b1);
		// expanded mode: every access of the port B address goes out
		do_reset(1'b1);
		wb(16'h1002, 1'b1, 8'h22, 8'h00);
		// internal read with visibility: data shows on port C, direction pin floats
		wb(16'h1006, 1'b1, 8'ha5, 8'h00);
		fork
			wb(16'h1006, 1'b0, 8'h00, 8'ha5);
			begin
				@(posedge clk_i iff e_clk_o === 1'b1);
				check({sb_oe_n, pc_o}, {1'b1, 8'ha5});
				check(pc_oe_n, 8'h00);
			end
		join
		v = 8'($random(seed));
		fork
			wb(16'h1004, 1'b1, v, 8'h00);
			begin
				@(posedge clk_i iff sa_o === 1'b1);
				check({sa_oe_n, sb_o, hi_o}, {2'b00, 8'h10});
				check(pc_oe_n, 8'h00);
			end
		join
		check(last_adr, 16'h1004);
		check(last_wdat, v);
		n0 = sb_changes;
		wb(16'h2345, 1'b1, 8'h12, 8'h00);
		wb(16'h2346, 1'b1, 8'h34, 8'h00);
		check(16'(sb_changes - n0), 16'h0000);
		check(last_wdat, 8'h34);
		for (int k = 0; k < 4; k++) begin
			a = 16'h4000 | 16'($random(seed) & 32'h3fff);
			wb(a, 1'b0, 8'h00, ext_rd(a));
		end
		repeat (4) @(posedge clk_i);
		stop_test();
	end
endmodule : mpp_ports_bench
